// [bench/txc_capture_monitor.sv]
// Port-level checker for the transmit capture block, bound to txc_capture.
// Assumes one core clock domain; link clocks are only sampled as data here.
`timescale 1ns/1ps
module txc_capture_monitor #(
  parameter int DEPTH = 8
) (
  input wire logic                      I_CLOCK,
  input wire logic                      I_RST,
  input wire logic                      I_TX_CLOCK_SHARED,
  input wire logic                      I_TX_CLOCK_CD,
  input wire logic                      I_TX_CLOCK_EF,
  input wire logic                      I_TX_CLOCK_GH,
  input wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_AB,
  input wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_CD,
  input wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_EF,
  input wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_GH,
  input wire logic                      I_INDEPENDENT,
  input wire logic                      I_NIBBLE,
  input wire logic                      I_CODE,
  input wire logic [7:0]                O_SERIAL,
  input wire logic [7:0]                O_K_CHAR,
  input wire logic [3:0]                O_SER_START,
  input wire logic [3:0]                O_OVERFLOW
);
  // A full FIFO plus the word in flight drains well inside this many cycles.
  localparam int QMAX = 16 * (DEPTH + 2);
  wire logic [3:0] lk = {I_TX_CLOCK_GH, I_TX_CLOCK_EF, I_TX_CLOCK_CD,
                         I_TX_CLOCK_SHARED};
  logic [3:0] lk_ff;
  int         quiet_ff;
  always_ff @(posedge I_CLOCK) begin
    lk_ff    <= lk;
    quiet_ff <= (I_RST || lk_ff != lk) ? 0 : quiet_ff + 1;
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  sequence s_two_zero(logic [1:0] s);
    s == 2'h0 ##1 s == 2'h0;
  endsequence
  AST_RST_CLEAR: assert property (disable iff (1'b0) I_RST |=>
    (O_SERIAL | O_K_CHAR | {O_SER_START, O_OVERFLOW}) == 8'h00)
    else $error("outputs not cleared by reset");
  AST_OVF_STICKY: assert property (($past(O_OVERFLOW) & ~O_OVERFLOW) == 4'h0)
    else $error("overflow flag dropped without reset");
  AST_QUIET_NO_START: assert property (quiet_ff > QMAX |-> O_SER_START == 4'h0)
    else $error("word started with links idle");
  AST_K_UNCODED: assert property ((!I_CODE) [*8] |->
    O_K_CHAR == 8'h00)
    else $error("K flag raised with encoder off");
  for (genvar b = 0; b < 4; b++) begin : g_bus
    AST_START_GAP: assert property (O_SER_START[b] |=>
      (!O_SER_START[b]) [*8] ##1 !O_SER_START[b])
      else $error("new word started inside a word");
    AST_K_STANDS: assert property (O_SER_START[b] |=>
      $stable(O_K_CHAR[2*b+:2]) [*8] ##1 $stable(O_K_CHAR[2*b+:2]))
      else $error("K flag moved during a word");
    AST_TAIL_IDLE: assert property (O_SER_START[b] |-> ##10
      (O_SER_START[b] || O_SERIAL[2*b+:2] == 2'h0))
      else $error("serial line not idle after ten bits");
    AST_CODED_TOP: assert property ((I_CODE [*8] ##0 O_SER_START[b])
      |-> ##8 s_two_zero(O_SERIAL[2*b+:2]))
      else $error("coded word has nonzero bits 8 and 9");
  end
endmodule : txc_capture_monitor

bind txc_capture txc_capture_monitor #(.DEPTH(DEPTH)) u_monitor (.*);

// [bench/txc_capture_tb.sv]
// Self-checking bench for the transmit capture block.
// Assumes the far-end model and the bound checker are compiled first.
`timescale 1ns/1ps
module txc_capture_tb;
  logic                           I_CLOCK = 1'b0;
  logic                           I_RST = 1'b1;
  logic                           I_INDEPENDENT = 1'b0;
  logic                           I_NIBBLE = 1'b0;
  logic                           I_CODE = 1'b0;
  logic [3:0]                     lclk;
  logic [3:0][txc_pkg::BUS_W-1:0] bus;
  logic [7:0]                     O_SERIAL;
  logic [7:0]                     O_K_CHAR;
  logic [3:0]                     O_SER_START;
  logic [3:0]                     O_OVERFLOW;
  int                             num_errors = 0;
  int                             check_count = 0;
  int                             cnt [4] = '{default: 0};
  txc_pkg::txc_pair_word_t        acc [4];
  txc_pkg::txc_pair_word_t        got_q [4][$];
  logic [39:0] rv = {10'h0B9, 10'h36E, 10'h2D4, 10'h1AB};
  logic [39:0] fv = {10'h2F3, 10'h155, 10'h0AA, 10'h3C5};

  always #10 I_CLOCK = ~I_CLOCK;

  txc_capture #(.DEPTH(2)) dut (
    .I_CLOCK          (I_CLOCK),
    .I_RST            (I_RST),
    .I_TX_CLOCK_SHARED(lclk[0]),
    .I_TX_CLOCK_CD    (lclk[1]),
    .I_TX_CLOCK_EF    (lclk[2]),
    .I_TX_CLOCK_GH    (lclk[3]),
    .I_TX_BUS_AB      (bus[0]),
    .I_TX_BUS_CD      (bus[1]),
    .I_TX_BUS_EF      (bus[2]),
    .I_TX_BUS_GH      (bus[3]),
    .I_INDEPENDENT    (I_INDEPENDENT),
    .I_NIBBLE         (I_NIBBLE),
    .I_CODE           (I_CODE),
    .O_SERIAL         (O_SERIAL),
    .O_K_CHAR         (O_K_CHAR),
    .O_SER_START      (O_SER_START),
    .O_OVERFLOW       (O_OVERFLOW)
  );
  txc_far_end u_far (.i_code(I_CODE), .o_clk(lclk), .o_bus(bus));

  // Rebuild each word from the serial lines, bit 0 first.
  always @(posedge I_CLOCK) begin
    for (int b = 0; b < 4; b++) begin
      if (O_SER_START[b]) begin
        cnt[b] = 1;
        acc[b] = '0;
        acc[b].even.k = O_K_CHAR[2*b];
        acc[b].odd.k = O_K_CHAR[2*b+1];
      end else if (cnt[b] > 0) begin
        cnt[b]++;
      end
      if (cnt[b] > 0) begin
        acc[b].even.data[cnt[b]-1] = O_SERIAL[2*b];
        acc[b].odd.data[cnt[b]-1] = O_SERIAL[2*b+1];
      end
      if (cnt[b] == 10) begin
        got_q[b].push_back(acc[b]);
        cnt[b] = 0;
      end
    end
  end

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic txc_pkg::txc_pair_word_t exp_pair(
    input logic [9:0] r, input logic [9:0] f, input logic nib, code);
    txc_pkg::txc_pair_word_t w;
    w = '0;
    if (!nib && !code) begin
      w.odd.data = r;
      w.even.data = f;
    end else if (!nib) begin
      {w.odd.k, w.odd.data[7:0]} = r[8:0];
      {w.even.k, w.even.data[7:0]} = f[8:0];
    end else if (!code) begin
      w.even.data = {r[4:0], f[4:0]};
      w.odd.data = {r[9:5], f[9:5]};
    end else begin
      w.even.k = r[3];
      w.even.data[7:0] = {r[4], r[2:0], f[4], f[2:0]};
      w.odd.k = r[8];
      w.odd.data[7:0] = {r[9], r[7:5], f[9], f[7:5]};
    end
    return w;
  endfunction : exp_pair

  task automatic set_mode(input logic ind, nib, code);
    @(posedge I_CLOCK);
    I_INDEPENDENT <= ind;
    I_NIBBLE <= nib;
    I_CODE <= code;
    repeat (8) @(posedge I_CLOCK);
  endtask : set_mode

  task automatic pair_test(input logic [3:0] mask, input logic nib, code,
                           input logic [3:0] want);
    logic [9:0] r;
    logic [9:0] f;
    u_far.send(mask, rv, fv);
    repeat (60) @(posedge I_CLOCK);
    for (int b = 0; b < 4; b++) begin
      r = rv[10*b+:10] & (code ? 10'h1FF : 10'h3FF);
      f = fv[10*b+:10] & (code ? 10'h1FF : 10'h3FF);
      if (!want[b])
        check(22'(got_q[b].size()), 22'h0);
      else if (got_q[b].size() == 0)
        check('x, exp_pair(r, f, nib, code));
      else
        check(got_q[b].pop_front(), exp_pair(r, f, nib, code));
    end
  endtask : pair_test

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    #60000;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge I_CLOCK);
    // Link clocks must run for the reset to reach the link logic.
    for (int i = 0; i < 3; i++) u_far.send(4'hF, rv, fv);
    @(posedge I_CLOCK);
    I_RST <= 1'b0;
    for (int i = 0; i < 3; i++) u_far.send(4'hF, rv, fv);
    repeat (80) @(posedge I_CLOCK);
    for (int b = 0; b < 4; b++) got_q[b].delete();
    @(negedge I_CLOCK);
    check(22'(O_OVERFLOW), 22'h0);
    $display("test reset done");
    set_mode(1'b0, 1'b0, 1'b0);
    pair_test(4'h1, 1'b0, 1'b0, 4'hF);
    set_mode(1'b0, 1'b0, 1'b1);
    pair_test(4'h1, 1'b0, 1'b1, 4'hF);
    set_mode(1'b0, 1'b1, 1'b0);
    pair_test(4'h1, 1'b1, 1'b0, 4'hF);
    set_mode(1'b0, 1'b1, 1'b1);
    pair_test(4'h1, 1'b1, 1'b1, 4'hF);
    $display("test modes done");
    set_mode(1'b1, 1'b0, 1'b0);
    pair_test(4'hE, 1'b0, 1'b0, 4'hE);
    pair_test(4'h1, 1'b0, 1'b0, 4'h1);
    $display("test independent done");
    set_mode(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 24; i++) u_far.send(4'h1, rv, fv);
    @(negedge I_CLOCK);
    check(22'(O_OVERFLOW), 22'hF);
    repeat (200) @(posedge I_CLOCK);
    while (got_q[0].size() > 0)
      check(got_q[0].pop_front(),
            exp_pair(rv[9:0], fv[9:0], 1'b0, 1'b0));
    $display("test overflow done");
    final_report();
  end
endmodule : txc_capture_tb

// [bench/txc_far_end.sv]
// Behavioural protocol device driving the four pair buses and link clocks.
// Assumes calls to send are serialised; clocks rest low between pairs.
`timescale 1ns/1ps
module txc_far_end (
  input  wire logic                      i_code,
  output logic [3:0]                     o_clk,
  output logic [3:0][txc_pkg::BUS_W-1:0] o_bus
);
  // The block has no reference input; this 125 MHz clock stands in for it.
  logic ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  initial begin
    o_clk = 4'h0;
    o_bus = '0;
  end
  // One pair per 160 ns; the 7 ns lead keeps link edges off core edges.
  task automatic send(input logic [3:0] mask, input logic [39:0] r,
                      input logic [39:0] f);
    logic [39:0] m;
    m = i_code ? {4{10'h1FF}} : {4{10'h3FF}};
    #7;
    o_bus = r & m;
    #40;
    o_clk = mask;
    #40;
    o_bus = f & m;
    #40;
    o_clk = 4'h0;
    #33;
    // Released lines show the inverse so stale data is never mistaken.
    o_bus = ~(f & m);
  endtask : send
endmodule : txc_far_end

// [pkg/txc_pkg.sv]
// Constants and carrier types for the transmit parallel DDR capture block.
// Assumes a 50 MHz core clock and source-synchronous link clocks per pair bus.
//
// Contract
// - Synchronized modes: shared clock captures all buses.
// - Independent modes: shared clock captures A/B only.
// - Independent: C/D, E/F, G/H use own clocks.
// - Serial output sends word bit 0 first.
// - Multiplexed: B on rising, A on falling.
// - Multiplexed: D on rising, C on falling.
// - Nibble: MS nibble rising, LS nibble falling.
// - Nibble: C on lines 4:0, D 9:5.
// - Nibble coded: line 3 flags K, even channel.
// - Multiplexed: bit 8 is ninth bit or K.
// - Nibble: bit 8 is odd channel bits/K.
package txc_pkg;

  localparam int BUS_W      = 10;
  localparam int NUM_BUS    = 4;
  localparam int NUM_LANE   = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int NIB_W      = 5;
  localparam int NIB_K_POS  = 3;
  localparam int MUX_K_POS  = 8;
  localparam int BYTE_W     = 8;
  localparam int SER_BITS   = 10;
  localparam logic [3:0] SER_LAST = 4'h9;

  typedef struct packed {
    logic             k;
    logic [BUS_W-1:0] data;
  } txc_ch_word_t;

  typedef struct packed {
    txc_ch_word_t odd;
    txc_ch_word_t even;
  } txc_pair_word_t;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b01,
    SER_SHIFT = 2'b10
  } txc_ser_state_t;

endpackage : txc_pkg

// [verilog/txc_capture.sv]
// Transmit parallel capture: DDR lanes, word FIFO and per-channel serializer.
// Assumes the pair buses change in step with their link clocks and that the
// mode pins are quasi-static; I_RST is synchronous to I_CLOCK.
`timescale 1ns/1ps

module txc_fifo #(
  parameter int W     = 22,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  // Storage has no reset: only the pointers and the count need a known state.
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : txc_fifo

// One pair bus sampled on both edges of one link clock.
module txc_ddr_lane (
  input  wire logic                      link_clk,
  input  wire logic                      core_rst,
  input  wire logic [txc_pkg::BUS_W-1:0] bus,
  output logic [2*txc_pkg::BUS_W-1:0]    pair_ff,
  output logic                           tog_ff
);
  logic                      rst_meta_ff;
  logic                      rst_sync_ff;
  logic [txc_pkg::BUS_W-1:0] rise_ff;

  // The core reset reaches this domain only while the link clock runs.
  always_ff @(posedge link_clk) begin
    rst_meta_ff <= core_rst;
    rst_sync_ff <= rst_meta_ff;
  end

  // The rising half opens a pair and the falling half closes it.
  always_ff @(posedge link_clk) begin
    rise_ff <= bus;
  end

  // The pair is held a whole link period, far longer than the crossing.
  always_ff @(negedge link_clk) begin
    if (rst_sync_ff) begin
      pair_ff <= '0;
      tog_ff  <= 1'b0;
    end else begin
      pair_ff <= {rise_ff, bus};
      tog_ff  <= ~tog_ff;
    end
  end
endmodule : txc_ddr_lane

module txc_capture #(
  parameter int DEPTH = txc_pkg::FIFO_DEPTH
) (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST,
  input  wire logic                      I_TX_CLOCK_SHARED,
  input  wire logic                      I_TX_CLOCK_CD,
  input  wire logic                      I_TX_CLOCK_EF,
  input  wire logic                      I_TX_CLOCK_GH,
  input  wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_AB,
  input  wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_CD,
  input  wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_EF,
  input  wire logic [txc_pkg::BUS_W-1:0] I_TX_BUS_GH,
  input  wire logic                      I_INDEPENDENT,
  input  wire logic                      I_NIBBLE,
  input  wire logic                      I_CODE,
  output logic [2*txc_pkg::NUM_BUS-1:0]  O_SERIAL,
  output logic [2*txc_pkg::NUM_BUS-1:0]  O_K_CHAR,
  output logic [txc_pkg::NUM_BUS-1:0]    O_SER_START,
  output logic [txc_pkg::NUM_BUS-1:0]    O_OVERFLOW
);
  localparam int BW = txc_pkg::BUS_W;
  localparam int NB = txc_pkg::NUM_BUS;
  localparam int NL = txc_pkg::NUM_LANE;
  localparam int PW = $bits(txc_pkg::txc_pair_word_t);

  // Lane wiring and output slicing assume four ten-line buses; a FIFO
  // shallower than two cannot hold a pair while the serializer is busy.
  if (NB != 4 || NL != 2 * NB - 1 || BW != 10 || DEPTH < 2) begin : g_bad_cfg
    $error("Unsupported bus count or FIFO depth.");
  end

  // Splits one captured pair into its two channel words.
  function automatic txc_pkg::txc_pair_word_t decode_pair(
    input logic [BW-1:0] rise,
    input logic [BW-1:0] fall,
    input logic          nibble,
    input logic          code
  );
    txc_pkg::txc_pair_word_t       pw;
    logic [txc_pkg::NIB_W-1:0]     re;
    logic [txc_pkg::NIB_W-1:0]     fe;
    logic [txc_pkg::NIB_W-1:0]     ro;
    logic [txc_pkg::NIB_W-1:0]     fo;
    pw = '0;
    re = rise[txc_pkg::NIB_W-1:0];
    fe = fall[txc_pkg::NIB_W-1:0];
    ro = rise[BW-1:txc_pkg::NIB_W];
    fo = fall[BW-1:txc_pkg::NIB_W];
    if (!nibble) begin
      pw.odd.data  = rise;
      pw.even.data = fall;
      if (code) begin
        // Bit 9 is ignored here, so a floating line cannot corrupt data.
        pw.odd.k     = rise[txc_pkg::MUX_K_POS];
        pw.even.k    = fall[txc_pkg::MUX_K_POS];
        pw.odd.data  = {2'h0, rise[txc_pkg::BYTE_W-1:0]};
        pw.even.data = {2'h0, fall[txc_pkg::BYTE_W-1:0]};
      end
    end else begin
      // Lines 4:0 carry the even channel, lines 9:5 the odd one.
      pw.even.data = {re, fe};
      pw.odd.data  = {ro, fo};
      if (code) begin
        pw.even.k    = re[txc_pkg::NIB_K_POS];
        pw.odd.k     = ro[txc_pkg::NIB_K_POS];
        pw.even.data = {2'h0, re[4], re[2:0], fe[4], fe[2:0]};
        pw.odd.data  = {2'h0, ro[4], ro[2:0], fo[4], fo[2:0]};
      end
    end
    return pw;
  endfunction : decode_pair

  logic [BW-1:0] lane_bus [NL];
  logic [NL-1:0] lane_clk;
  logic [2*BW-1:0] lane_pair [NL];
  logic [NL-1:0] lane_tog;

  assign lane_bus[0] = I_TX_BUS_AB;
  assign lane_bus[1] = I_TX_BUS_CD;
  assign lane_bus[2] = I_TX_BUS_EF;
  assign lane_bus[3] = I_TX_BUS_GH;
  assign lane_bus[4] = I_TX_BUS_CD;
  assign lane_bus[5] = I_TX_BUS_EF;
  assign lane_bus[6] = I_TX_BUS_GH;
  assign lane_clk = {I_TX_CLOCK_GH, I_TX_CLOCK_EF, I_TX_CLOCK_CD,
                     {NB{I_TX_CLOCK_SHARED}}};

  // Lanes 0-3 run on the shared clock, 4-6 on the per-pair clocks.
  for (genvar l = 0; l < NL; l++) begin : g_lane
    txc_ddr_lane u_lane (
      .link_clk (lane_clk[l]),
      .core_rst (I_RST),
      .bus      (lane_bus[l]),
      .pair_ff  (lane_pair[l]),
      .tog_ff   (lane_tog[l])
    );
  end

  logic [2:0]    mode_meta_ff;
  logic [2:0]    mode_sync_ff;
  logic [NL-1:0] tog_meta_ff;
  logic [NL-1:0] tog_sync_ff;
  logic [NL-1:0] tog_prev_ff;
  logic          indep;
  logic          nibble;
  logic          code;

  // Only the toggles and mode pins pass through flops; the pair word is read
  // once its toggle has settled, while it still stands for a link period.
  always_ff @(posedge I_CLOCK) begin
    mode_meta_ff <= {I_INDEPENDENT, I_NIBBLE, I_CODE};
    mode_sync_ff <= mode_meta_ff;
    tog_meta_ff  <= lane_tog;
    tog_sync_ff  <= tog_meta_ff;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      tog_prev_ff <= '0;
    end else begin
      tog_prev_ff <= tog_sync_ff;
    end
  end

  assign {indep, nibble, code} = mode_sync_ff;

  for (genvar b = 0; b < NB; b++) begin : g_bus
    localparam int SRC = (b == 0) ? 0 : b + NB - 1;

    logic                    sel_new;
    logic [2*BW-1:0]         sel_pair;
    txc_pkg::txc_pair_word_t in_word;
    logic                    in_ready;
    logic                    out_valid;
    logic                    out_ready;
    txc_pkg::txc_pair_word_t out_word;
    txc_pkg::txc_ser_state_t state_ff;
    logic [3:0]              cnt_ff;
    logic [BW-1:0]           sh_even_ff;
    logic [BW-1:0]           sh_odd_ff;
    logic [1:0]              k_ff;
    logic                    ovf_ff;
    logic                    word_end;

    // A/B always follows the shared clock; others switch on the mode.
    always_comb begin
      if (indep && b != 0) begin
        sel_new  = tog_sync_ff[SRC] ^ tog_prev_ff[SRC];
        sel_pair = lane_pair[SRC];
      end else begin
        sel_new  = tog_sync_ff[b] ^ tog_prev_ff[b];
        sel_pair = lane_pair[b];
      end
    end

    assign in_word = decode_pair(sel_pair[2*BW-1:BW], sel_pair[BW-1:0],
                                 nibble, code);

    txc_fifo #(
      .W     (PW),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clk       (I_CLOCK),
      .rst       (I_RST),
      .in_valid  (sel_new),
      .in_ready  (in_ready),
      .in_data   (in_word),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_word)
    );

    // The link cannot be stalled, so a full FIFO drops the pair.
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        ovf_ff <= 1'b0;
      end else if (sel_new && !in_ready) begin
        ovf_ff <= 1'b1;
      end
    end

    assign out_ready = (state_ff == txc_pkg::SER_IDLE);
    // High while the last of the ten bits is on the line.
    assign word_end  = (state_ff == txc_pkg::SER_SHIFT) &&
                       (cnt_ff == txc_pkg::SER_LAST);

    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        state_ff <= txc_pkg::SER_IDLE;
      end else begin
        case (state_ff)
          txc_pkg::SER_IDLE: begin
            if (out_valid) begin
              state_ff <= txc_pkg::SER_SHIFT;
            end
          end
          txc_pkg::SER_SHIFT: begin
            if (word_end) begin
              state_ff <= txc_pkg::SER_IDLE;
            end
          end
          default: begin
            state_ff <= txc_pkg::SER_IDLE;
          end
        endcase
      end
    end

    // Ten bits per word at the core rate, least significant bit first.
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        cnt_ff     <= 4'h0;
        sh_even_ff <= '0;
        sh_odd_ff  <= '0;
      end else if (out_valid && out_ready) begin
        cnt_ff     <= 4'h0;
        sh_even_ff <= out_word.even.data;
        sh_odd_ff  <= out_word.odd.data;
      end else if (state_ff == txc_pkg::SER_SHIFT) begin
        cnt_ff     <= cnt_ff + 4'h1;
        sh_even_ff <= {1'b0, sh_even_ff[BW-1:1]};
        sh_odd_ff  <= {1'b0, sh_odd_ff[BW-1:1]};
      end
    end

    // The K flag belongs to the word on the line, so it drops with the last
    // bit; a stale flag would mark idle cycles as control characters.
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        k_ff <= 2'h0;
      end else if (out_valid && out_ready) begin
        k_ff <= {out_word.odd.k, out_word.even.k};
      end else if (word_end) begin
        k_ff <= 2'h0;
      end
    end

    assign O_SERIAL[2*b]     = sh_even_ff[0];
    assign O_SERIAL[2*b+1]   = sh_odd_ff[0];
    assign O_K_CHAR[2*b+:2]  = k_ff;
    assign O_SER_START[b]    = (state_ff == txc_pkg::SER_SHIFT) &&
                               (cnt_ff == 4'h0);
    assign O_OVERFLOW[b]     = ovf_ff;
  end
endmodule : txc_capture
